// [design/drbuf_top.v]
// Double row character buffer: two byte rows, one loaded while other is shown
// Notes on behaviour
// - two byte rows, length 2 to 135
// - write clock with both gates stores, advances
// - either gate low blocks write and advance
// - read enable loads output latch each read clock
// - read trailing edge advances pointer and pipeline
// - valid data two read clocks after enable
// - swap rows when swap and clear low
// - clear low zeroes read pointer next rise
// - clear during swap zeroes write pointer too
// - write full flag at 135, blocks writes
// - read end flag at 135, blocks reads
// - outputs float second read rise after flag
// - output enable low drives, high floats
// - clear falling edge caught, width irrelevant
`timescale 1ns/1ns
`include "drbuf_map.vh"
module drbuf_top #(
  parameter DEPTH = `DRBUF_DEPTH
) (
  // System clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Write side pins
  input wire wclk_i,
  input wire write_gate_a_i,
  input wire write_gate_b_i,
  input wire [7:0] row_byte_in_i,
  output reg write_full_flag_o,
  // Read side pins
  input wire rclk_i,
  input wire read_enable_i,
  input wire buffer_swap_n_i,
  input wire pointer_clear_n_i,
  input wire out_enable_n_i,
  output reg read_end_flag_o,
  // Data out, value and enable of a tri-state pin
  output reg [7:0] row_byte_out_o,
  output reg row_byte_out_oe_n_o
);
  localparam [7:0] LAST = `DRBUF_LAST;

  // Row memories
  reg [7:0] row_a [0:DEPTH-1];
  reg [7:0] row_b [0:DEPTH-1];

  // Synchronised pins
  wire wgate_a_s, wgate_b_s, ren_s, swap_n_s, clr_n_s, oe_n_s;
  wire [7:0] din_s;
  wire wrise, rrise, rfall;

  // Pointers and selection
  reg wsel_ff; // Row currently being written: 0 = A
  reg [7:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
  reg clr_last_ff; // Previous clear level for edge
  reg clr_pend_ff; // Clear caught, waits for read rise
  reg swap_pend_ff; // Swap caught, waits for read rise
  reg swap_tog_ff; // Toggle on each swap, read side
  reg wswap_last_ff; // Write side copy of toggle
  wire swap_tog_s;
  reg rstop_ff; // Reading halted after last position
  reg [7:0] pipe_ff; // First pipeline stage
  reg [1:0] ren_pipe_ff; // Enable history for validity
  reg [1:0] float_cnt_ff; // Rises since read end flag
  reg wstop_ff; // Writing halted after last position

  // Increment used on both pointers
  // Saturates at the last slot so a full row never wraps onto slot zero
  function [7:0] drbuf_inc;
    input [7:0] p;
    begin
      drbuf_inc = (p == LAST) ? p : p + 8'h01;
    end
  endfunction

  // Clock edge finders
  drbuf_edge u_wedge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .lclk_i(wclk_i),
    .rise_o(wrise),
    .fall_o()
  );
  drbuf_edge u_redge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .lclk_i(rclk_i),
    .rise_o(rrise),
    .fall_o(rfall)
  );

  // Synchronisers for every pin input
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_din
      drbuf_sync u_s (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(row_byte_in_i[gi]),
        .q_o(din_s[gi])
      );
    end
  endgenerate
  // Write gates, active high
  drbuf_sync u_s_wa (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(write_gate_a_i),
    .q_o(wgate_a_s)
  );

  drbuf_sync u_s_wb (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(write_gate_b_i),
    .q_o(wgate_b_s)
  );

  // Read enable, active high
  drbuf_sync u_s_re (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(read_enable_i),
    .q_o(ren_s)
  );

  // Swap and clear idle high; reset to that level so no false edge follows reset
  drbuf_sync #(
    .RST_VAL(1'b1)
  ) u_s_sw (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(buffer_swap_n_i),
    .q_o(swap_n_s)
  );

  drbuf_sync #(
    .RST_VAL(1'b1)
  ) u_s_cl (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(pointer_clear_n_i),
    .q_o(clr_n_s)
  );

  // Output enable, active low, idles low
  drbuf_sync u_s_oe (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(out_enable_n_i),
    .q_o(oe_n_s)
  );

  // Swap toggle into write bookkeeping, kept as a proper crossing
  drbuf_sync u_s_tg (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(swap_tog_ff),
    .q_o(swap_tog_s)
  );

  // Write gate condition
  wire wr_go = wrise & wgate_a_s & wgate_b_s & ~wstop_ff;
  wire swap_w = swap_tog_s ^ wswap_last_ff;

  // Next write pointer
  // Swap zeroes the pointer, else each gated write advances
  always @* begin
    nxt_wptr = wptr_ff;
    if (swap_w) begin
      nxt_wptr = `DRBUF_PTR_RST;
    end else if (wr_go) begin
      nxt_wptr = drbuf_inc(wptr_ff);
    end
  end

  // Write side state
  // A swap outranks a write; the gates should be low then anyway
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wsel_ff <= `DRBUF_SEL_RST;
      wptr_ff <= `DRBUF_PTR_RST;
      wswap_last_ff <= 1'b0;
      wstop_ff <= 1'b0;
      write_full_flag_o <= 1'b0;
    end else begin
      wswap_last_ff <= swap_tog_s;
      wptr_ff <= nxt_wptr;
      if (swap_w) begin
        wsel_ff <= ~wsel_ff;
        wstop_ff <= 1'b0;
        write_full_flag_o <= 1'b0;
      end else if (wr_go) begin
        if (wptr_ff == LAST) begin
          wstop_ff <= 1'b1;
        end
        write_full_flag_o <= (wptr_ff == LAST);
      end else if (wrise & ~(wgate_a_s & wgate_b_s)) begin
        write_full_flag_o <= 1'b0;
      end
    end
  end

  // Row storage writes
  // A write landing in the swap cycle is dropped, the writer must wait
  always @(posedge clk_i) begin
    if (wr_go & ~swap_w) begin
      if (wsel_ff) begin
        row_b[wptr_ff] <= din_s;
      end else begin
        row_a[wptr_ff] <= din_s;
      end
    end
  end

  // Clear and swap capture on the read side
  // A clear fall seen between read rises is held until the next rise
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clr_last_ff <= 1'b1;
      clr_pend_ff <= 1'b0;
      swap_pend_ff <= 1'b0;
      swap_tog_ff <= 1'b0;
    end else begin
      clr_last_ff <= clr_n_s;
      if (rrise) begin
        clr_pend_ff <= 1'b0;
        swap_pend_ff <= 1'b0;
        if (swap_pend_ff | (~swap_n_s & ~clr_n_s)) begin
          swap_tog_ff <= ~swap_tog_ff;
        end
      end else begin
        if (clr_last_ff & ~clr_n_s) begin
          clr_pend_ff <= 1'b1;
          if (~swap_n_s) begin
            swap_pend_ff <= 1'b1;
          end
        end
      end
    end
  end

  // Read row is the one not being written. While a swap is still on its
  // way to the write side the read side already shows the freshly loaded
  // row, so the displayed row never lags the swap by the crossing delay.
  wire rsel = (swap_tog_ff ^ wswap_last_ff) ? wsel_ff : ~wsel_ff;
  wire clr_now = rrise & (clr_pend_ff | ~clr_n_s);
  wire rd_go = rfall & ren_s & ~rstop_ff;

  // Next read pointer
  // Clear on a read rise, advance on a read fall
  always @* begin
    nxt_rptr = rptr_ff;
    if (clr_now) begin
      nxt_rptr = `DRBUF_PTR_RST;
    end else if (rd_go) begin
      nxt_rptr = drbuf_inc(rptr_ff);
    end
  end

  // Read side state and output pipeline
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rptr_ff <= `DRBUF_PTR_RST;
      rstop_ff <= 1'b0;
      pipe_ff <= 8'h00;
      ren_pipe_ff <= 2'h0;
      float_cnt_ff <= 2'h0;
      read_end_flag_o <= 1'b0;
      row_byte_out_o <= 8'h00;
      row_byte_out_oe_n_o <= 1'b1;
    end else begin
      rptr_ff <= nxt_rptr;
      if (clr_now) begin
        rstop_ff <= 1'b0;
        read_end_flag_o <= 1'b0;
        float_cnt_ff <= 2'h0;
      end else if (rd_go) begin
        if (rptr_ff == LAST) begin
          rstop_ff <= 1'b1;
        end
        read_end_flag_o <= (rptr_ff == LAST);
      end
      if (rfall) begin
        pipe_ff <= rsel ? row_b[rptr_ff] : row_a[rptr_ff];
        ren_pipe_ff <= {ren_pipe_ff[0], ren_s & ~rstop_ff};
        if (ren_pipe_ff[0]) begin
          row_byte_out_o <= pipe_ff;
        end
      end
      // Count read rises after the end flag; float on the second
      if (rrise & read_end_flag_o & ~clr_now & (float_cnt_ff != 2'h2)) begin
        float_cnt_ff <= float_cnt_ff + 2'h1;
      end
      row_byte_out_oe_n_o <= oe_n_s | (float_cnt_ff == 2'h2);
    end
  end
endmodule

// [design/drbuf_map.vh]
// Constants for the double row character buffer
`ifndef DRBUF_MAP_VH
`define DRBUF_MAP_VH
`define DRBUF_DEPTH 135
`define DRBUF_LAST 8'h86
`define DRBUF_MIN_LEN 2
`define DRBUF_AW 8
`define DRBUF_DW 8
`define DRBUF_PTR_RST 8'h00
`define DRBUF_SEL_RST 1'b0
`define DRBUF_PIPE_DEPTH 2
`endif

// [design/drbuf_sync.v]
// Two flip-flop synchroniser for one level
`timescale 1ns/1ns
module drbuf_sync #(
  parameter RST_VAL = 1'b0 // Level held in reset, the pin's idle level
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Level in and out
  input wire d_i,
  output wire q_o
);
  reg meta_ff; // First stage, read only by second
  reg q_ff; // Second stage

  // Shift the level through two stages
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end
  assign q_o = q_ff;
endmodule

// [design/drbuf_edge.v]
// Synchronised link clock with rise and fall pulses
`timescale 1ns/1ns
module drbuf_edge (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Raw clock from outside
  input wire lclk_i,
  // Edge pulses
  output reg rise_o,
  output reg fall_o
);
  wire lsync; // Synchronised level
  reg last_ff; // Previous synchronised level

  drbuf_sync u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(lclk_i),
    .q_o(lsync)
  );

  // Remember last level
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= lsync;
    end
  end

  // Edge decode
  always @* begin
    rise_o = lsync & ~last_ff;
    fall_o = ~lsync & last_ff;
  end
endmodule

// [verification/drbuf_top_props.sv]
// Port checks for the double row buffer
`timescale 1ns/1ns
module drbuf_top_props #(
  parameter DEPTH = 135
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Write side
  input wire wclk_i,
  input wire write_gate_a_i,
  input wire write_gate_b_i,
  input wire [7:0] row_byte_in_i,
  input wire write_full_flag_o,
  // Read side
  input wire rclk_i,
  input wire read_enable_i,
  input wire buffer_swap_n_i,
  input wire pointer_clear_n_i,
  input wire out_enable_n_i,
  input wire read_end_flag_o,
  input wire [7:0] row_byte_out_o,
  input wire row_byte_out_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Output enable held off long enough to pass the synchroniser
  sequence s_off;
    out_enable_n_i [*6];
  endsequence
  // Read end flag just rose
  sequence s_end;
    $rose(read_end_flag_o);
  endsequence
  // Write full flag just rose
  sequence s_full;
    $rose(write_full_flag_o);
  endsequence
  AST_OE_FLOAT: assert property (s_off |-> row_byte_out_oe_n_o)
    else $error("data driven while output enable is off");
  AST_END_FLOAT: assert property (s_end |-> ##[1:30] row_byte_out_oe_n_o)
    else $error("data still driven after read end");
  AST_END_CAUSE: assert property (s_end |-> read_enable_i)
    else $error("read end flag without reading");
  AST_END_HOLD: assert property (pointer_clear_n_i [*8] ##0 read_end_flag_o |=> read_end_flag_o)
    else $error("read end flag dropped without clear");
  AST_FULL_HOLD: assert property (write_full_flag_o && write_gate_a_i && write_gate_b_i
    && buffer_swap_n_i |=> write_full_flag_o)
    else $error("write full flag dropped while writing");
  AST_FULL_CAUSE: assert property (s_full |-> buffer_swap_n_i)
    else $error("write full flag rose during swap");
  AST_FULL_GATES: assert property (s_full |-> write_gate_a_i && write_gate_b_i)
    else $error("write full flag rose with a gate low");
  AST_DATA_HOLD: assert property ((!read_enable_i) [*8] |=> $stable(row_byte_out_o))
    else $error("data out moved with read enable low");
endmodule
bind drbuf_top drbuf_top_props #(.DEPTH(DEPTH)) u_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .wclk_i(wclk_i), .write_gate_a_i(write_gate_a_i), .write_gate_b_i(write_gate_b_i),
  .row_byte_in_i(row_byte_in_i), .write_full_flag_o(write_full_flag_o), .rclk_i(rclk_i),
  .read_enable_i(read_enable_i), .buffer_swap_n_i(buffer_swap_n_i),
  .pointer_clear_n_i(pointer_clear_n_i), .out_enable_n_i(out_enable_n_i),
  .read_end_flag_o(read_end_flag_o), .row_byte_out_o(row_byte_out_o),
  .row_byte_out_oe_n_o(row_byte_out_oe_n_o));

// [verification/drbuf_link_clk.sv]
// Link clock source of the far side, running only inside a frame
`timescale 1ns/1ns
module drbuf_link_clk #(
  parameter PH = 13
) (
  // Frame gate
  input wire run_i,
  // Link clock out
  output reg lclk_o
);
  // Offset phase, 400 ns period, parked low outside frames
  initial begin
    lclk_o = 1'b0;
    #PH;
    forever begin
      #200;
      lclk_o = run_i ? ~lclk_o : 1'b0;
    end
  end
endmodule

// [verification/drbuf_top_test.sv]
// Testbench for the double row buffer
`timescale 1ns/1ns
module drbuf_top_test;
  reg clk_i, rst_b_i, ga, gb, ren, sw_n, cl_n, oe_n, wrun, rrun;
  reg [7:0] din;
  wire wclk, rclk, wfull, rend, qoe_n;
  wire [7:0] q;
  integer fails, n_compared, k;
  drbuf_link_clk #(.PH(13)) u_w (.run_i(wrun), .lclk_o(wclk));
  drbuf_link_clk #(.PH(37)) u_r (.run_i(rrun), .lclk_o(rclk));
  drbuf_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wclk_i(wclk), .write_gate_a_i(ga),
    .write_gate_b_i(gb), .row_byte_in_i(din), .write_full_flag_o(wfull), .rclk_i(rclk),
    .read_enable_i(ren), .buffer_swap_n_i(sw_n), .pointer_clear_n_i(cl_n),
    .out_enable_n_i(oe_n), .read_end_flag_o(rend), .row_byte_out_o(q),
    .row_byte_out_oe_n_o(qoe_n));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task tick; begin @(posedge clk_i); #1; end endtask
  task chk(input [7:0] got, input [7:0] exp); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  end endtask
  task test_done; begin
    $display("mismatches %0d of %0d compares", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  // Wait for a link clock pin level, bounded; r set picks the read clock
  task wlvl(input r, input v);
    integer t;
    begin
      t = 0;
      while (((r ? rclk : wclk) !== v) && (t < 40)) begin
        tick;
        t = t + 1;
      end
      if (t >= 40) begin
        fails = fails + 1;
        test_done;
      end
    end
  endtask
  // Write n bytes from base, gate a as given
  task wrow(input [7:0] base, input integer n, input g); begin
    ga = g; gb = 1'b1; din = base; tick; wrun = 1'b1;
    for (k = 0; k < n; k = k + 1) begin
      wlvl(1'b0, 1'b1); wlvl(1'b0, 1'b0); din = base + k[7:0] + 8'h01;
    end
    wrun = 1'b0; ga = 1'b0; gb = 1'b0; repeat (12) tick;
  end endtask
  // Clear pulse, with or without swap
  task clr(input s); begin
    sw_n = ~s; cl_n = 1'b0; rrun = 1'b1;
    // Release right after the first read rise so exactly one swap lands
    wlvl(1'b1, 1'b0); wlvl(1'b1, 1'b1);
    cl_n = 1'b1; sw_n = 1'b1; rrun = 1'b0; repeat (12) tick;
  end endtask
  // Read n rclk periods, check bytes from third rise
  task rrow(input integer n); begin
    ren = 1'b1; tick; rrun = 1'b1;
    for (k = 0; k < n; k = k + 1) begin
      wlvl(1'b1, 1'b0); wlvl(1'b1, 1'b1); tick;
      if (k >= 2) chk(q, 8'h0E + k[7:0]);
    end
  end endtask
  initial begin
    #400000;
    fails = fails + 1;
    test_done;
  end
  initial begin
    fails = 0; n_compared = 0; rst_b_i = 1'b0; ga = 1'b0; gb = 1'b0; ren = 1'b0;
    sw_n = 1'b1; cl_n = 1'b1; oe_n = 1'b0; wrun = 1'b0; rrun = 1'b0; din = 8'h00;
    repeat (2) tick;
    chk(qoe_n, 8'h01);
    rst_b_i = 1'b1;
    repeat (4) tick;
    chk(wfull, 8'h00);
    chk(qoe_n, 8'h00);
    wrow(8'hE0, 3, 1'b0);
    wrow(8'h10, 136, 1'b1);
    chk(wfull, 8'h01);
    clr(1'b1);
    chk(wfull, 8'h00);
    rrow(137);
    repeat (4) begin wlvl(1'b1, 1'b0); wlvl(1'b1, 1'b1); end
    rrun = 1'b0; ren = 1'b0; repeat (8) tick;
    chk(rend, 8'h01);
    chk(qoe_n, 8'h01);
    clr(1'b0);
    chk(rend, 8'h00);
    oe_n = 1'b1;
    rrow(5);
    chk(qoe_n, 8'h01);
    oe_n = 1'b0; rrun = 1'b0; ren = 1'b0; repeat (8) tick;
    chk(qoe_n, 8'h00);
    test_done;
  end
endmodule
